/* design/cfs_fuse_top.sv */
// module: power-up capture of configuration bytes and protection bits
`timescale 1ns/100ps
// Overview of operation
// - configuration fixed at power up; software cannot change it later
// - two nonvolatile configuration bytes, programmed like code memory
// - first configuration byte readable by data move at fd00
// - undefined oscillator select codes are reported as reserved
// - both protection bits unprogrammed: programming and verify allowed
// - only first bit programmed: programming refused, second bit still allowed
// - both protection bits programmed: verify and programming blocked
// - watchdog fuse cleared lets the timer run as interval timer
module cfs_fuse_top
  import cfs_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_cfg1_fuse,
  input wire logic [7:0] i_cfg2_fuse,
  input wire logic [1:0] i_sec_fuse,
  input wire logic i_rd,
  input wire logic [15:0] i_addr,
  input wire logic i_prog_req,
  input wire logic i_verify_req,
  input wire logic i_protect_bit_two_req,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic o_prog_grant,
  output logic o_verify_grant,
  output logic o_protect_bit_two_grant,
  output logic o_wdog_enable,
  output logic o_interval_mode,
  output logic o_rstpin_disable,
  output logic o_port_reset_high,
  output logic o_brownout_enable,
  output logic o_clk_div6,
  output logic [2:0] o_osc_mode,
  output logic o_osc_reserved,
  output logic o_cfg_valid
);
  ////////////////////////////////////////////////////////////////////////////
  // fuse inputs settle from the array, so synchronise before use
  logic [7:0] cfg1_s1_r, cfg1_s2_r, cfg2_s1_r, cfg2_s2_r;
  logic [1:0] sec_s1_r, sec_s2_r;
  always_ff @(posedge i_core_clk or posedge i_rst)
    if (i_rst)
    begin
      cfg1_s1_r <= CFS_CFG_UNPROG;
      cfg1_s2_r <= CFS_CFG_UNPROG;
      cfg2_s1_r <= CFS_CFG_UNPROG;
      cfg2_s2_r <= CFS_CFG_UNPROG;
      sec_s1_r <= CFS_SEC_UNPROG;
      sec_s2_r <= CFS_SEC_UNPROG;
    end
    else
    begin
      cfg1_s1_r <= i_cfg1_fuse;
      cfg1_s2_r <= cfg1_s1_r;
      cfg2_s1_r <= i_cfg2_fuse;
      cfg2_s2_r <= cfg2_s1_r;
      sec_s1_r <= i_sec_fuse;
      sec_s2_r <= sec_s1_r;
    end

  ////////////////////////////////////////////////////////////////////////////
  // capture once after reset release: 2 sync stages then latch
  logic [1:0] wait_r;
  logic cap_done_r;
  logic [7:0] cfg1_r, cfg2_r;
  logic [1:0] sec_r;
  always_ff @(posedge i_core_clk or posedge i_rst)
    if (i_rst)
      wait_r <= 2'h0;
    else if (wait_r != CFS_CAP_WAIT)
      wait_r <= wait_r + 2'h1;

  always_ff @(posedge i_core_clk or posedge i_rst)
    if (i_rst)
    begin
      cap_done_r <= 1'b0;
      cfg1_r <= CFS_CFG_UNPROG;
      cfg2_r <= CFS_CFG_UNPROG;
      sec_r <= CFS_SEC_UNPROG;
    end
    else if (!cap_done_r && wait_r == CFS_CAP_WAIT)
    begin
      // no write path exists; only reset reopens the capture
      cap_done_r <= 1'b1;
      cfg1_r <= cfg1_s2_r;
      cfg2_r <= cfg2_s2_r;
      sec_r <= sec_s2_r;
    end

  ////////////////////////////////////////////////////////////////////////////
  // protection decode in the gate module
  cfs_sec_if sec_bus ();
  assign sec_bus.sec = sec_r;
  cfs_sec_gate u_gate (.sec_bus(sec_bus));

  // grants held low until capture, so nothing slips through at power up
  always_ff @(posedge i_core_clk or posedge i_rst)
    if (i_rst)
    begin
      o_prog_grant <= 1'b0;
      o_verify_grant <= 1'b0;
      o_protect_bit_two_grant <= 1'b0;
    end
    else
    begin
      o_prog_grant <= cap_done_r && i_prog_req && sec_bus.prog_ok;
      o_verify_grant <= cap_done_r && i_verify_req && sec_bus.verify_ok;
      // only allowed once first bit set; guards against the combination
      o_protect_bit_two_grant <= cap_done_r && i_protect_bit_two_req
        && sec_bus.prot_two_ok && !sec_r[0];
    end

  ////////////////////////////////////////////////////////////////////////////
  // data-move read port, one-cycle answer
  always_ff @(posedge i_core_clk or posedge i_rst)
    if (i_rst)
    begin
      o_rdata <= 8'h00;
      o_rvalid <= 1'b0;
    end
    else
    begin
      o_rvalid <= i_rd;
      if (i_rd && i_addr == CFS_ADDR_CFG1)
        o_rdata <= cfg1_r;
      else if (i_rd && i_addr == CFS_ADDR_CFG2)
        o_rdata <= cfg2_r;
      else if (i_rd)
        o_rdata <= 8'h00;
    end

  ////////////////////////////////////////////////////////////////////////////
  // decoded settings
  cfs_osc_t osc_nxt;
  always_comb
  begin
    unique case (cfg1_r[CFS_OSC_HI:0])
      CFS_OSC_EXT: osc_nxt = CFS_CK_EXT;
      CFS_OSC_RC: osc_nxt = CFS_CK_RC;
      CFS_OSC_LOW: osc_nxt = CFS_CK_LOW;
      CFS_OSC_MED: osc_nxt = CFS_CK_MED;
      CFS_OSC_HIGH: osc_nxt = CFS_CK_HIGH;
      default: osc_nxt = CFS_CK_RSVD;
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
    if (i_rst)
    begin
      o_wdog_enable <= 1'b0;
      o_interval_mode <= 1'b0;
      o_rstpin_disable <= 1'b0;
      o_port_reset_high <= 1'b1;
      o_brownout_enable <= 1'b0;
      o_clk_div6 <= 1'b0;
      o_osc_mode <= CFS_CK_EXT;
      o_osc_reserved <= 1'b0;
      o_cfg_valid <= 1'b0;
    end
    else
    begin
      o_wdog_enable <= cap_done_r && cfg1_r[CFS_BIT_WDOG];
      o_interval_mode <= cap_done_r && !cfg1_r[CFS_BIT_WDOG];
      o_rstpin_disable <= cap_done_r && !cfg1_r[CFS_BIT_RSTPIN];
      o_port_reset_high <= cfg1_r[CFS_BIT_PORTHI];
      o_brownout_enable <= cap_done_r && cfg1_r[CFS_BIT_BROWN];
      o_clk_div6 <= cap_done_r && !cfg1_r[CFS_BIT_CLKDIV];
      o_osc_mode <= osc_nxt;
      o_osc_reserved <= (osc_nxt == CFS_CK_RSVD);
      o_cfg_valid <= cap_done_r;
    end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_hold_cfg;
    @(posedge i_core_clk) disable iff (i_rst)
      cap_done_r |=> $stable(cfg1_r) && $stable(sec_r) && cap_done_r;
  endproperty
  a_hold_cfg: assert property (p_hold_cfg) else $error("config changed");

  property p_no_write;
    @(posedge i_core_clk) disable iff (i_rst)
      o_cfg_valid |=> $stable(o_osc_mode) && $stable(o_wdog_enable);
  endproperty
  a_no_write: assert property (p_no_write) else $error("decoded changed");

  property p_cap_time;
    @(posedge i_core_clk) disable iff (i_rst)
      $rose(cap_done_r) |-> cfg1_r == $past(cfg1_s2_r);
  endproperty
  a_cap_time: assert property (p_cap_time) else $error("capture mismatch");

  sequence s_rd_cfg1;
    i_rd && i_addr == CFS_ADDR_CFG1 && cap_done_r;
  endsequence
  property p_rd;
    @(posedge i_core_clk) disable iff (i_rst)
      s_rd_cfg1 |=> o_rvalid && o_rdata == $past(cfg1_r);
  endproperty
  a_rd: assert property (p_rd) else $error("read data wrong");

  property p_rsvd;
    @(posedge i_core_clk) disable iff (i_rst)
      cap_done_r && cfg1_r[2:0] inside {3'h4, 3'h5, 3'h6} |=> o_osc_reserved;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved osc missed");

  property p_open;
    @(posedge i_core_clk) disable iff (i_rst)
      cap_done_r && sec_r == 2'h3 && i_prog_req && i_verify_req
        |=> o_prog_grant && o_verify_grant;
  endproperty
  a_open: assert property (p_open) else $error("open part refused");

  property p_first_lock;
    @(posedge i_core_clk) disable iff (i_rst)
      sec_r == 2'h2 |=> !o_prog_grant;
  endproperty
  a_first_lock: assert property (p_first_lock) else $error("program after lock");

  property p_second_open;
    @(posedge i_core_clk) disable iff (i_rst)
      cap_done_r && sec_r == 2'h2 && i_protect_bit_two_req |=> o_protect_bit_two_grant;
  endproperty
  a_second_open: assert property (p_second_open) else $error("second bit refused");

  property p_locked;
    @(posedge i_core_clk) disable iff (i_rst)
      sec_r == 2'h0 |=> !o_prog_grant && !o_verify_grant && !o_protect_bit_two_grant;
  endproperty
  a_locked: assert property (p_locked) else $error("locked part accessed");

  property p_wdog;
    @(posedge i_core_clk) disable iff (i_rst)
      cap_done_r && !cfg1_r[CFS_BIT_WDOG] |=> o_interval_mode && !o_wdog_enable;
  endproperty
  a_wdog: assert property (p_wdog) else $error("interval mode missing");
endmodule

/* pkg/cfs_pkg.sv */
// package: constants for the configuration fuse and security block
package cfs_pkg;
  localparam logic [15:0] CFS_ADDR_CFG1 = 16'hfd00;
  localparam logic [15:0] CFS_ADDR_CFG2 = 16'hfd01;
  localparam int CFS_BIT_WDOG = 7;
  localparam int CFS_BIT_RSTPIN = 6;
  localparam int CFS_BIT_PORTHI = 5;
  localparam int CFS_BIT_BROWN = 4;
  localparam int CFS_BIT_CLKDIV = 3;
  localparam int CFS_OSC_HI = 2;
  localparam logic [7:0] CFS_CFG_UNPROG = 8'hff;
  localparam logic [1:0] CFS_SEC_UNPROG = 2'h3;
  // capture waits out both synchroniser stages after reset release
  localparam logic [1:0] CFS_CAP_WAIT = 2'h2;
  localparam logic [2:0] CFS_OSC_EXT = 3'h7;
  localparam logic [2:0] CFS_OSC_RC = 3'h3;
  localparam logic [2:0] CFS_OSC_LOW = 3'h2;
  localparam logic [2:0] CFS_OSC_MED = 3'h1;
  localparam logic [2:0] CFS_OSC_HIGH = 3'h0;
  typedef enum logic [2:0]
  {
    CFS_CK_HIGH = 3'h0,
    CFS_CK_MED = 3'h1,
    CFS_CK_LOW = 3'h2,
    CFS_CK_RC = 3'h3,
    CFS_CK_EXT = 3'h4,
    CFS_CK_RSVD = 3'h5
  } cfs_osc_t;
  // protection decode, index is {protect_bit_two, protect_bit_one}
  function automatic logic [1:0] cfs_sec_allow(input logic [1:0] sec);
    // returns {program_allowed, verify_allowed}
    case (sec)
      2'h3: cfs_sec_allow = 2'h3;
      2'h2: cfs_sec_allow = 2'h1;
      default: cfs_sec_allow = 2'h0;
    endcase
  endfunction
endpackage

/* pkg/cfs_sec_if.sv */
// interface: protection state between the fuse latch and the access gate
`timescale 1ns/100ps
interface cfs_sec_if;
  logic [1:0] sec;
  logic prog_ok;
  logic verify_ok;
  logic prot_two_ok;
  modport src (output sec, input prog_ok, input verify_ok, input prot_two_ok);
  modport gate (input sec, output prog_ok, output verify_ok, output prot_two_ok);
endinterface

/* design/cfs_sec_gate.sv */
// module: decodes the two protection bits into access permissions
`timescale 1ns/100ps
module cfs_sec_gate
  import cfs_pkg::*;
(
  cfs_sec_if.gate sec_bus
);
  logic [1:0] allow;
  assign allow = cfs_sec_allow(sec_bus.sec);
  assign sec_bus.prog_ok = allow[1];
  assign sec_bus.verify_ok = allow[0];
  // second protection bit stays programmable until that bit itself is set
  assign sec_bus.prot_two_ok = sec_bus.sec[1];
endmodule

/* dv/cfs_fuse_model.sv */
// model: fuse array contents as left by the serial programmer
`timescale 1ns/100ps
module cfs_fuse_model
  import cfs_pkg::*;
(
  input wire logic [7:0] i_cfg1_set,
  input wire logic [7:0] i_cfg2_set,
  input wire logic [1:0] i_sec_set,
  output logic [7:0] o_cfg1,
  output logic [7:0] o_cfg2,
  output logic [1:0] o_sec
);
  // both bytes burned like code memory, held as levels
  assign o_cfg1 = i_cfg1_set;
  assign o_cfg2 = i_cfg2_set;
  // a lone second protection bit is never burned, so that request leaves it blank
  assign o_sec = (i_sec_set == 2'h1) ? CFS_SEC_UNPROG : i_sec_set;
endmodule

/* dv/cfs_fuse_top_tb.sv */
// testbench: configuration fuse and security block
`timescale 1ns/100ps
module cfs_fuse_top_tb;
  import cfs_pkg::*;
  logic i_core_clk, i_rst, i_rd, i_prog_req, i_verify_req, i_protect_bit_two_req;
  logic [15:0] i_addr;
  logic [7:0] cfg1_set, cfg2_set, cfg1_w, cfg2_w, o_rdata;
  logic [1:0] sec_set, sec_w;
  logic o_rvalid, o_prog_grant, o_verify_grant, o_protect_bit_two_grant, o_wdog_enable;
  logic o_interval_mode, o_rstpin_disable, o_port_reset_high, o_brownout_enable;
  logic o_clk_div6, o_osc_reserved, o_cfg_valid;
  logic [2:0] o_osc_mode;
  int mismatches, cmp_count;
  ////////////////////////////////////////////////////////////////////////////////
  cfs_fuse_model cfs_fuse_model_inst (.i_cfg1_set(cfg1_set), .i_cfg2_set(cfg2_set),
    .i_sec_set(sec_set), .o_cfg1(cfg1_w), .o_cfg2(cfg2_w), .o_sec(sec_w));
  cfs_fuse_top cfs_fuse_top_inst (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_cfg1_fuse(cfg1_w), .i_cfg2_fuse(cfg2_w), .i_sec_fuse(sec_w), .i_rd(i_rd),
    .i_addr(i_addr), .i_prog_req(i_prog_req), .i_verify_req(i_verify_req),
    .i_protect_bit_two_req(i_protect_bit_two_req), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .o_prog_grant(o_prog_grant), .o_verify_grant(o_verify_grant),
    .o_protect_bit_two_grant(o_protect_bit_two_grant), .o_wdog_enable(o_wdog_enable),
    .o_interval_mode(o_interval_mode), .o_rstpin_disable(o_rstpin_disable),
    .o_port_reset_high(o_port_reset_high), .o_brownout_enable(o_brownout_enable),
    .o_clk_div6(o_clk_div6), .o_osc_mode(o_osc_mode), .o_osc_reserved(o_osc_reserved),
    .o_cfg_valid(o_cfg_valid));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    if (mismatches == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // codes 4 to 6 have no meaning and come back as reserved
  function automatic logic [2:0] exp_osc(input logic [2:0] c);
    case (c)
      3'h7: exp_osc = 3'h4;
      3'h4, 3'h5, 3'h6: exp_osc = 3'h5;
      default: exp_osc = c;
    endcase
  endfunction
  task automatic boot(input logic [7:0] c1, input logic [7:0] c2, input logic [1:0] s);
    @(posedge i_core_clk);
    cfg1_set <= c1;
    cfg2_set <= c2;
    sec_set <= s;
    i_rst <= 1'b1;
    @(posedge i_core_clk);
    #1;
    check({2'h0, o_cfg_valid, o_port_reset_high, o_rvalid, o_osc_mode}, 8'h14);
    @(posedge i_core_clk);
    i_rst <= 1'b0;
    repeat (6) @(posedge i_core_clk);
    #1;
  endtask
  task automatic check_cfg(input logic [7:0] c);
    check({o_wdog_enable, o_interval_mode, o_rstpin_disable, o_port_reset_high,
      o_brownout_enable, o_clk_div6, o_cfg_valid, o_osc_reserved},
      {c[7], !c[7], !c[6], c[5], c[4], !c[3], 1'b1, exp_osc(c[2:0]) == 3'h5});
    check({5'h0, o_osc_mode}, {5'h0, exp_osc(c[2:0])});
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1;
    check({7'h0, o_rvalid}, 8'h01);
    check(o_rdata, e);
  endtask
  task automatic req(input logic [1:0] s);
    @(posedge i_core_clk);
    {i_prog_req, i_verify_req, i_protect_bit_two_req} <= 3'h7;
    @(posedge i_core_clk);
    #1;
    check({5'h0, o_prog_grant, o_verify_grant, o_protect_bit_two_grant},
      {5'h0, s == 2'h3, s[1], s == 2'h2});
    @(posedge i_core_clk);
    {i_prog_req, i_verify_req, i_protect_bit_two_req} <= 3'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end
  // whole run is under two hundred cycles; this cuts a hang short
  initial
  begin
    #200us;
    mismatches++;
    conclude();
  end
  initial
  begin
    logic [31:0] r;
    logic [7:0] c1;
    void'($urandom(18852));
    {i_rst, i_rd, i_prog_req, i_verify_req, i_protect_bit_two_req} = 5'h10;
    {i_addr, cfg1_set, cfg2_set, sec_set} = {16'h0, 8'hff, 8'hff, 2'h3};
    mismatches = 0;
    cmp_count = 0;
    for (int k = 0; k < 8; k++)
    begin
      r = $urandom;
      c1 = {r[7:3], k[2:0]};
      boot(c1, r[15:8], 2'h3);
      check_cfg(c1);
      rd(CFS_ADDR_CFG1, c1);
      rd(CFS_ADDR_CFG2, r[15:8]);
      rd(r[31:16] | 16'h0002, 8'h00);
      cfg1_set <= ~c1;
      rd(CFS_ADDR_CFG1, c1);
      check_cfg(c1);
    end
    for (int s = 0; s < 4; s++)
    begin
      boot(8'hff, 8'hff, s[1:0]);
      req(sec_w);
    end
    conclude();
  end
endmodule
